// ---- verilog/sio_core.sv ----
// clocked serial interface, receive and transmit/receive modes, with avalon-mm registers
`timescale 1ns/1ns
`include "sio_defs.svh"

module sio_core (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic        sck_in,
  output logic             sck_out,
  output logic             sck_oe,
  input  wire logic        si,
  output logic             so,
  output logic             serial_irq
);
  import sio_pkg::*;

  ctrl_t      ctrl_r;
  logic [2:0] count_r;
  logic [7:0] buf_r [0:7];
  sio_state_t state_r;
  sio_state_t state_nxt;
  logic       busy_r;
  logic [2:0] word_idx_r;
  logic [2:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic       pending_r;
  logic       sck_d_r;
  logic       tick;
  logic       sck_s;
  logic       si_s;

  // half period of the internal serial clock in system cycles
  function automatic logic [12:0] rate_half(input logic [2:0] sel);
    case (sel)
      3'h0:    rate_half = `HALF_SEL0;
      3'h1:    rate_half = `HALF_SEL1;
      3'h2:    rate_half = `HALF_SEL2;
      3'h3:    rate_half = `HALF_SEL3;
      3'h4:    rate_half = `HALF_SEL4;
      default: rate_half = `HALF_SEL5;
    endcase
  endfunction : rate_half

  // pin inputs come from the peer's domain
  sio_sync #(.W(2)) u_sync (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .d       ({sck_in, si}),
    .q       ({sck_s, si_s})
  );

  // bus decode; an access is taken on the edge where waitrequest is seen low
  wire       req_w      = read | write;
  wire       acc_w      = req_w & ~waitrequest;
  wire       wr_w       = write & acc_w & byteenable[0];
  wire       rd_w       = read & acc_w;
  wire       is_buf_w   = address[5];
  wire [2:0] buf_sel_w  = address[4:2];
  wire       wr_ctrl1_w = wr_w && (address == `CTRL1_OFS);
  wire       wr_ctrl2_w = wr_w && (address == `CTRL2_OFS);
  wire       wr_buf_w   = wr_w && is_buf_w;
  wire       rd_buf_w   = rd_w && is_buf_w;
  wire [1:0] wr_mode_w  = writedata[`MODE_MSB:`MODE_LSB];
  wire       wr_mode_ok = (wr_mode_w == `MODE_RX) || (wr_mode_w == `MODE_TXRX);
  wire       inhibit_w  = wr_ctrl1_w & writedata[`INHIBIT_BIT];
  wire       start_req_w = wr_ctrl1_w & writedata[`START_BIT] & ~writedata[`INHIBIT_BIT]
                           & wr_mode_ok & (state_r == ST_IDLE);
  wire       mode_chg_w = wr_ctrl1_w && (wr_mode_w != ctrl_r.mode);

  // register read selection; unmapped addresses read zero
  wire [7:0] ctrl1_rd_w = {ctrl_r.start, 1'b0, ctrl_r.mode, ctrl_r.len8, ctrl_r.clk_sel};
  wire [7:0] stat_rd_w  = {busy_r, state_r == ST_SHIFT, 6'h00};
  wire [7:0] rd_mux_w   = is_buf_w                  ? buf_r[buf_sel_w] :
                          (address == `CTRL1_OFS)   ? ctrl1_rd_w :
                          (address == `CTRL2_OFS)   ? {5'h00, count_r} :
                          (address == `STAT_OFS)    ? stat_rd_w : 8'h00;

  // fixed one-wait-state answer: data is loaded with the first wait cycle
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
    end else if (req_w && waitrequest) begin
      waitrequest <= 1'b0;
      readdata    <= {24'h00_0000, rd_mux_w};
    end else begin
      waitrequest <= 1'b1;
    end
  end

  // control registers; inhibit is a command bit and always reads zero
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r  <= `CTRL1_RESET;
      count_r <= `CTRL2_RESET;
    end else begin
      if (wr_ctrl1_w) begin
        ctrl_r.start   <= writedata[`START_BIT] & ~writedata[`INHIBIT_BIT];
        ctrl_r.mode    <= wr_mode_w;
        ctrl_r.len8    <= writedata[`LEN_BIT];
        ctrl_r.clk_sel <= writedata[`CLKSEL_MSB:0];
      end
      if (wr_ctrl2_w) begin
        count_r <= writedata[2:0];
      end
    end
  end

  // serial clock edges: internal from the divider, external from the synchronised pin
  wire internal_w = (ctrl_r.clk_sel != `CLK_EXT);
  wire txrx_w     = (ctrl_r.mode == `MODE_TXRX);
  wire shifting_w = (state_r == ST_SHIFT);
  wire lead_w     = shifting_w && (internal_w ? (tick && sck_out) : (sck_d_r && !sck_s));
  wire trail_w    = shifting_w && (internal_w ? (tick && !sck_out) : (!sck_d_r && sck_s));

  sio_rate_div #(.CW(13)) u_div (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .run      (shifting_w && internal_w),
    .half_cnt (rate_half(ctrl_r.clk_sel)),
    .tick     (tick)
  );

  // lsb first: new bit enters at the top of the word, 4-bit words keep a zero upper nibble
  wire       wide_w    = ctrl_r.len8 | txrx_w;
  wire [2:0] last_idx_w = wide_w ? 3'h7 : 3'h3;
  wire [7:0] word_w    = wide_w ? {si_s, shift_r[7:1]} : {4'h0, si_s, shift_r[3:1]};
  wire       last_w    = trail_w && (bit_cnt_r == last_idx_w);

  // end-of-word decisions
  wire       rx_block_w   = last_w && !txrx_w && pending_r;
  wire       wait_rx_in_w = rx_block_w && internal_w;
  wire       abort_w      = rx_block_w && !internal_w;
  wire       wait_rx_done = (state_r == ST_WAIT) && !txrx_w && !pending_r;
  wire       store_w      = (last_w && !rx_block_w) || wait_rx_done;
  wire [7:0] store_data_w = (state_r == ST_WAIT) ? shift_r : word_w;
  wire       full_w       = store_w && (word_idx_r == count_r);
  wire       end_w        = store_w && !ctrl_r.start;
  wire [2:0] next_idx_w   = full_w ? 3'h0 : 3'(word_idx_r + 3'h1);
  wire       wait_tx_in_w = store_w && txrx_w && internal_w && ctrl_r.start
                            && (full_w || pending_r);
  wire       wait_tx_done = (state_r == ST_WAIT) && txrx_w && !pending_r;
  wire       tx_next_w    = store_w && txrx_w && !wait_tx_in_w && !end_w;

  // inhibit outranks everything, start only from idle
  assign state_nxt = inhibit_w                      ? ST_IDLE :
                     start_req_w                    ? ST_SHIFT :
                     (abort_w || end_w)             ? ST_IDLE :
                     (wait_rx_in_w || wait_tx_in_w) ? ST_WAIT :
                     (wait_rx_done || wait_tx_done) ? ST_SHIFT : state_r;

  // sequencing state and busy flag
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
      busy_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      busy_r  <= (state_nxt != ST_IDLE);
    end
  end

  // bit and word position
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      bit_cnt_r  <= 3'h0;
      word_idx_r <= 3'h0;
    end else begin
      if (start_req_w || last_w) begin
        bit_cnt_r <= 3'h0;
      end else if (trail_w) begin
        bit_cnt_r <= 3'(bit_cnt_r + 3'h1);
      end
      if (start_req_w) begin
        word_idx_r <= 3'h0;
      end else if (store_w) begin
        word_idx_r <= next_idx_w;
      end
    end
  end

  // shift register: loads transmit data at word start in combined mode, samples on trailing edge
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_r <= 8'h00;
    end else if (start_req_w) begin
      shift_r <= buf_r[0];
    end else if (tx_next_w) begin
      shift_r <= buf_r[next_idx_w];
    end else if (wait_tx_done) begin
      shift_r <= buf_r[word_idx_r];
    end else if (trail_w) begin
      shift_r <= word_w;
    end
  end

  // unread/unwritten buffer marker; setting at buffer full beats a same-cycle clear
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pending_r <= 1'b0;
    end else if (start_req_w) begin
      pending_r <= 1'b0;
    end else if (full_w) begin
      pending_r <= 1'b1;
    end else if (txrx_w ? wr_buf_w : rd_buf_w) begin
      pending_r <= 1'b0;
    end
  end

  // data buffer: mode change clears it, a stored word beats a bus write to the same word
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 8; i++) begin
        buf_r[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (mode_chg_w) begin
          buf_r[i] <= 8'h00;
        end else if (store_w && (word_idx_r == 3'(i))) begin
          buf_r[i] <= store_data_w;
        end else if (wr_buf_w && (buf_sel_w == 3'(i))) begin
          buf_r[i] <= writedata[7:0];
        end
      end
    end
  end

  // pins: clock idles high and stops outside shifting, which is how the wait halts it
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sck_out    <= 1'b1;
      sck_oe     <= 1'b0;
      so         <= 1'b1;
      sck_d_r    <= 1'b1;
      serial_irq <= 1'b0;
    end else begin
      sck_oe     <= internal_w;
      sck_d_r    <= sck_s;
      serial_irq <= full_w;
      if (!shifting_w || !internal_w) begin
        sck_out <= 1'b1;
      end else if (tick) begin
        sck_out <= ~sck_out;
      end
      if (lead_w && txrx_w) begin
        so <= shift_r[0];
      end else if (state_nxt == ST_IDLE) begin
        so <= 1'b1;
      end
    end
  end

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  property p_start_busy;
    start_req_w |=> busy_r && (state_r == ST_SHIFT) && (word_idx_r == 3'h0);
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("busy not set at start");

  property p_inhibit;
    inhibit_w |=> !busy_r && (state_r == ST_IDLE);
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("inhibit did not end transfer");

  property p_inhibit_txrx;
    inhibit_w && txrx_w |=> !busy_r ##1 !busy_r;
  endproperty
  a_inhibit_txrx: assert property (p_inhibit_txrx) else $error("combined inhibit failed");

  property p_irq;
    full_w |=> serial_irq ##1 !serial_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("buffer interrupt not a single pulse");

  property p_ext_abort;
    abort_w |=> !busy_r && (word_idx_r == $past(word_idx_r));
  endproperty
  a_ext_abort: assert property (p_ext_abort) else $error("overrun word was stored");

  property p_rx_wait;
    wait_rx_in_w && !rd_buf_w |=> ((state_r == ST_WAIT) && sck_out) [*2];
  endproperty
  a_rx_wait: assert property (p_rx_wait) else $error("receive wait not held");

  property p_wait_cancel;
    (state_r == ST_WAIT) && !txrx_w && rd_buf_w |=> ##1 (state_r != ST_WAIT);
  endproperty
  a_wait_cancel: assert property (p_wait_cancel) else $error("buffer read kept wait");

  property p_nibble;
    store_w && !wide_w && !mode_chg_w |=> (buf_r[$past(word_idx_r)][7:4] == 4'h0);
  endproperty
  a_nibble: assert property (p_nibble) else $error("4-bit word upper nibble set");

  property p_order;
    store_w && !full_w && !start_req_w |=> (word_idx_r == 3'($past(word_idx_r) + 3'h1));
  endproperty
  a_order: assert property (p_order) else $error("buffer not filled upward");

  property p_end;
    end_w && !start_req_w |=> !busy_r;
  endproperty
  a_end: assert property (p_end) else $error("busy kept after final word");

  property p_so_lead;
    $changed(so) && $past(busy_r) && busy_r |-> $past(lead_w);
  endproperty
  a_so_lead: assert property (p_so_lead) else $error("serial out moved off leading edge");

  c_rx_full:   cover property (full_w && !txrx_w);
  c_rx_wait:   cover property (wait_rx_in_w ##[1:400] wait_rx_done);
  c_txrx_full: cover property (full_w && txrx_w);
  c_abort:     cover property (abort_w);
endmodule : sio_core

// ---- verilog/sio_defs.svh ----
// register map, field positions, reset values and clock-rate counts of the serial block
`ifndef SIO_DEFS_SVH
`define SIO_DEFS_SVH
`define CTRL1_OFS      6'h00
`define CTRL2_OFS      6'h04
`define STAT_OFS       6'h08
`define START_BIT      7
`define INHIBIT_BIT    6
`define MODE_MSB       5
`define MODE_LSB       4
`define LEN_BIT        3
`define CLKSEL_MSB     2
`define BUSY_BIT       7
`define SHIFTING_BIT   6
`define MODE_TX        2'h0
`define MODE_RX        2'h1
`define MODE_TXRX      2'h2
`define CLK_EXT        3'h7
`define CTRL1_RESET    7'h00
`define CTRL2_RESET    3'h0
`define HALF_SEL0      13'h1000
`define HALF_SEL1      13'h0080
`define HALF_SEL2      13'h0040
`define HALF_SEL3      13'h0020
`define HALF_SEL4      13'h0010
`define HALF_SEL5      13'h0008
`endif

// ---- verilog/sio_pkg.sv ----
// types shared by the serial block
package sio_pkg;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_WAIT  = 2'b10
  } sio_state_t;

  typedef struct packed {
    logic       start;
    logic [1:0] mode;
    logic       len8;
    logic [2:0] clk_sel;
  } ctrl_t;
endpackage : sio_pkg

// ---- verilog/sio_sync.sv ----
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module sio_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // first stage is read only by the second
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= '1;
      q      <= '1;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : sio_sync

// ---- verilog/sio_rate_div.sv ----
// half-period divider giving one-cycle ticks for the internal serial clock
`timescale 1ns/1ns
module sio_rate_div #(
  parameter int CW = 13
) (
  input  wire logic          sys_clk,
  input  wire logic          reset_n,
  input  wire logic          run,
  input  wire logic [CW-1:0] half_cnt,
  output logic               tick
);
  logic [CW-1:0] cnt_r;
  wire           hit_w = (cnt_r >= CW'(half_cnt - CW'(1)));

  // counter restarts whenever the clock is halted, so each run begins with a full half period
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else if (!run) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else begin
      cnt_r <= hit_w ? '0 : CW'(cnt_r + CW'(1));
      tick  <= hit_w;
    end
  end
endmodule : sio_rate_div

// ---- verif/sio_peer.sv ----
// far-side serial peer model
`timescale 1ns/1ns
module sio_peer (
  input  wire logic sck,
  input  wire logic so,
  output logic      si,
  output logic      ext_sck
);
  logic [63:0] tx_bits;
  logic [7:0]  rx_byte;

  initial begin
    si = 1'b1;
    ext_sck = 1'b1;
    tx_bits = 64'h0;
    rx_byte = 8'h0;
  end

  // next bit leaves on the falling edge, half a period before it is sampled
  always @(negedge sck) begin
    si <= tx_bits[0];
    tx_bits <= tx_bits >> 1;
  end

  // block output taken on the rising edge, lsb first
  always @(posedge sck) rx_byte <= {so, rx_byte[7:1]};

  // external clock runs only for the pulses asked for, idles high between
  task automatic pulses(input int n);
    #3;
    repeat (n) begin
      #80 ext_sck = 1'b0;
      #80 ext_sck = 1'b1;
    end
  endtask : pulses
endmodule : sio_peer

// ---- verif/tb.sv ----
// bench for the serial block: bus tasks, scenarios, verdict
`timescale 1ns/1ns
`include "sio_defs.svh"
module tb;
  logic        sys_clk, reset_n, read, write, waitrequest;
  logic        si, so, sck_out, sck_oe, serial_irq, sck_w, ext_sck;
  logic [5:0]  address;
  logic [3:0]  byteenable;
  logic [31:0] writedata, readdata, rd;
  int          num_errors, n_compared, cyc, irq_cnt;

  // the block owns the clock line only while its enable is high
  assign sck_w = sck_oe ? sck_out : ext_sck;

  sio_core sio_core_i (.sys_clk(sys_clk), .reset_n(reset_n), .address(address),
    .read(read), .write(write), .byteenable(byteenable), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .sck_in(sck_w), .sck_out(sck_out),
    .sck_oe(sck_oe), .si(si), .so(so), .serial_irq(serial_irq));
  sio_peer sio_peer_i (.sck(sck_w), .so(so), .si(si), .ext_sck(ext_sck));

  always #4 sys_clk = ~sys_clk;

  // hang guard and interrupt pulse count
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (serial_irq === 1'b1) irq_cnt <= irq_cnt + 1;
    if (cyc == 30000) begin
      num_errors++;
      results();
    end
  end

  task automatic results();
    if (num_errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one access, held until waitrequest is seen low; an idle edge follows
  task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
    address <= a;
    writedata <= {24'h0, d};
    write <= wr;
    read <= ~wr;
    do @(posedge sys_clk); while (waitrequest !== 1'b0);
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge sys_clk);
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rchk(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h0);
    chk(rd, exp);
  endtask : rchk

  function automatic logic [5:0] ba(input int i);
    return 6'h20 + 6'(4 * i);
  endfunction : ba

  function automatic logic [7:0] ctl(input logic s, input logic inh, input logic [1:0] m,
                                     input logic l8, input logic [2:0] c);
    return {s, inh, m, l8, c};
  endfunction : ctl

  // bounded wait for one interrupt pulse
  task automatic wait_irq();
    int b, k;
    b = irq_cnt;
    k = 0;
    while (irq_cnt == b && k < 3000) begin
      @(posedge sys_clk);
      k++;
    end
    chk(32'(irq_cnt - b), 32'h1);
  endtask : wait_irq

  task automatic t_reset();
    chk({28'h0, waitrequest, sck_out, so, serial_irq}, 32'he);
    rchk(`STAT_OFS, 32'h0);
    rchk(6'h10, 32'h0);
  endtask : t_reset

  // two 8-bit words on the internal clock, then inhibit
  task automatic t_rx_two();
    sio_peer_i.tx_bits = 64'h3ca5;
    wr(`CTRL2_OFS, 8'h01);
    wr(`CTRL1_OFS, ctl(1'b1, 1'b0, `MODE_RX, 1'b1, 3'h5));
    bus(1'b0, `STAT_OFS, 8'h0);
    chk(rd & 32'h80, 32'h80);
    wait_irq();
    rchk(ba(0), 32'ha5);
    rchk(ba(1), 32'h3c);
    // a word was read, so the third word must be taken without a wait
    repeat (200) @(posedge sys_clk);
    rchk(`STAT_OFS, 32'hc0);
    rchk(ba(0), 32'h00);
    wr(`CTRL1_OFS, ctl(1'b0, 1'b1, `MODE_RX, 1'b1, 3'h5));
    rchk(`STAT_OFS, 32'h0);
  endtask : t_rx_two

  // 4-bit words; clearing start lets the current word finish
  task automatic t_rx_nib();
    int k;
    sio_peer_i.tx_bits = 64'h6b;
    wr(`CTRL2_OFS, 8'h00);
    wr(`CTRL1_OFS, ctl(1'b1, 1'b0, `MODE_RX, 1'b0, 3'h5));
    wait_irq();
    rchk(ba(0), 32'h0b);
    wr(`CTRL1_OFS, ctl(1'b0, 1'b0, `MODE_RX, 1'b0, 3'h5));
    bus(1'b0, `STAT_OFS, 8'h0);
    chk(rd & 32'h80, 32'h80);
    k = 0;
    while (rd[7] !== 1'b0 && k < 200) begin
      bus(1'b0, `STAT_OFS, 8'h0);
      k++;
    end
    chk(rd, 32'h0);
    rchk(ba(0), 32'h06);
  endtask : t_rx_nib

  // unread buffer holds the clock; a read of an unused word releases it
  task automatic t_rx_wait();
    sio_peer_i.tx_bits = 64'h7e81;
    wr(`CTRL1_OFS, ctl(1'b1, 1'b0, `MODE_RX, 1'b1, 3'h5));
    wait_irq();
    repeat (300) @(posedge sys_clk);
    rchk(`STAT_OFS, 32'h80);
    chk({31'h0, sck_out}, 32'h1);
    wr(`CTRL2_OFS, 8'h01);
    rchk(ba(5), 32'h0);
    rchk(ba(0), 32'h7e);
    wr(`CTRL1_OFS, ctl(1'b0, 1'b1, `MODE_RX, 1'b1, 3'h5));
  endtask : t_rx_wait

  // external clock: first word unread, so the second is dropped and reception ends
  task automatic t_ext();
    sio_peer_i.tx_bits = 64'h335c;
    wr(`CTRL2_OFS, 8'h00);
    wr(`CTRL1_OFS, ctl(1'b1, 1'b0, `MODE_RX, 1'b1, `CLK_EXT));
    // the enable follows the clock select one edge after the write lands
    @(posedge sys_clk);
    chk({31'h0, sck_oe}, 32'h0);
    sio_peer_i.pulses(8);
    @(posedge sys_clk);
    wait_irq();
    sio_peer_i.pulses(8);
    repeat (10) @(posedge sys_clk);
    rchk(`STAT_OFS, 32'h0);
    rchk(ba(0), 32'h5c);
  endtask : t_ext

  // combined mode: word out and word in, then wait for a buffer write
  task automatic t_txrx();
    int k;
    wr(`CTRL1_OFS, ctl(1'b0, 1'b0, `MODE_TXRX, 1'b1, 3'h5));
    rchk(ba(0), 32'h0);
    wr(ba(0), 8'h5a);
    sio_peer_i.tx_bits = 64'hc3;
    wr(`CTRL1_OFS, ctl(1'b1, 1'b0, `MODE_TXRX, 1'b1, 3'h5));
    wait_irq();
    wr(`CTRL2_OFS, 8'h00);
    rchk(ba(0), 32'hc3);
    repeat (200) @(posedge sys_clk);
    rchk(`STAT_OFS, 32'h80);
    chk({24'h0, sio_peer_i.rx_byte}, 32'h5a);
    // start cleared in the wait; the buffer write releases one last word
    sio_peer_i.tx_bits = 64'h24;
    wr(`CTRL1_OFS, ctl(1'b0, 1'b0, `MODE_TXRX, 1'b1, 3'h5));
    wr(ba(0), 8'h81);
    k = 0;
    rd = 32'h80;
    while (rd[7] !== 1'b0 && k < 300) begin
      bus(1'b0, `STAT_OFS, 8'h0);
      k++;
    end
    chk(rd, 32'h0);
    rchk(ba(0), 32'h24);
    chk({24'h0, sio_peer_i.rx_byte}, 32'h81);
  endtask : t_txrx

  // combined mode on the external clock: data written ahead, no wait, inhibit mid-run
  task automatic t_txrx_ext();
    sio_peer_i.tx_bits = 64'h0f;
    wr(ba(0), 8'h96);
    wr(`CTRL1_OFS, ctl(1'b1, 1'b0, `MODE_TXRX, 1'b1, `CLK_EXT));
    sio_peer_i.pulses(8);
    @(posedge sys_clk);
    wait_irq();
    rchk(ba(0), 32'h0f);
    chk({24'h0, sio_peer_i.rx_byte}, 32'h96);
    rchk(`STAT_OFS, 32'hc0);
    wr(`CTRL1_OFS, ctl(1'b0, 1'b1, `MODE_TXRX, 1'b1, `CLK_EXT));
    rchk(`STAT_OFS, 32'h0);
  endtask : t_txrx_ext

  initial begin
    sys_clk = 1'b0;
    reset_n = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 6'h00;
    byteenable = 4'hf;
    writedata = 32'h0;
    num_errors = 0;
    n_compared = 0;
    cyc = 0;
    irq_cnt = 0;
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_rx_two();
    t_rx_nib();
    t_rx_wait();
    t_ext();
    t_txrx();
    t_txrx_ext();
    results();
  end
endmodule : tb
